// File: hdl/reset_sources_cfg.svh
// Addresses, field positions, reset values and timing figures of the reset-source block
`ifndef RESET_SOURCES_CFG_SVH
`define RESET_SOURCES_CFG_SVH

`define ADDR_SUPPLY_CTRL    8'hFF
`define ADDR_RESET_CAUSE    8'hEF
`define ADDR_IRQ_STATUS     8'hE0
`define ADDR_IRQ_CLEAR      8'hE1
`define ADDR_IRQ_ENABLE     8'hE2

`define BIT_MONITOR_ON      7
`define BIT_SUPPLY_ABOVE    6
`define BIT_PIN_CAUSE       0
`define BIT_POWER_CAUSE     1
`define BIT_CLOCK_CAUSE     2

`define IRQ_SUPPLY_DROP     0
`define IRQ_CLOCK_LOST      1
`define IRQ_PIN_RESET       2

`define CAUSE_AFTER_POWER   3'h2
`define CAUSE_AFTER_PIN     3'h1
`define CAUSE_AFTER_CLOCK   3'h4

`define CLOCK_PERIOD_NS     25
`define POR_DELAY_NS        300000
`define MONITOR_SETTLE_NS   100000
`define CLOCK_TIMEOUT_NS    500
`define CLOCK_HOLD_NS       100

`endif

// File: hdl/reset_sources_pkg.sv
// Types shared by the reset-source block and its clock-loss detector
package reset_sources_pkg;

    typedef enum logic [1:0] {
        ST_POWER_ON  = 2'b00,
        ST_RUN       = 2'b01,
        ST_HOLD      = 2'b10,
        ST_CLOCKHOLD = 2'b11
    } seq_state_t;

    typedef enum logic [1:0] {
        CAUSE_NONE   = 2'b00,
        CAUSE_SUPPLY = 2'b01,
        CAUSE_PIN    = 2'b10,
        CAUSE_CLOCK  = 2'b11
    } cause_t;

    typedef struct packed {
        seq_state_t  fsm;
        cause_t      pend;
        logic [15:0] holdCnt;
        logic [11:0] settleCnt;
        logic        monitorOn;
        logic        supplySel;
        logic        clockLossEn;
        logic [2:0]  causeFlags;
        logic [2:0]  irqStatus;
        logic [2:0]  irqEnable;
        logic        irq;
        logic [7:0]  rdData;
        logic        coreReset;
        logic        pinOe;
        logic        supplyPrev;
    } seq_regs_t;

    typedef struct packed {
        logic       prevSense;
        logic [7:0] count;
        logic       lost;
    } detector_regs_t;

endpackage

// File: hdl/clock_loss_detector.sv
// Retriggerable one-shot that flags a system clock stuck high or low
`timescale 1ns/1ps
`include "reset_sources_cfg.svh"

module clock_loss_detector
    import reset_sources_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic clockSense,
    output logic      lost
);

    // Longest time, so the count rounds down
    localparam int TimeoutCycles = `CLOCK_TIMEOUT_NS / `CLOCK_PERIOD_NS;

    detector_regs_t r_q;
    detector_regs_t r_d;

    always_comb
    begin
        r_d = r_q;
        r_d.prevSense = clockSense;
        if (!enable)
        begin
            r_d.count = 8'h00;
            r_d.lost  = 1'b0;
        end
        else if (clockSense != r_q.prevSense)
        begin
            r_d.count = 8'h00;
        end
        else if (r_q.count == 8'(TimeoutCycles - 1))
        begin
            r_d.lost = 1'b1;
        end
        else
        begin
            r_d.count = r_q.count + 8'h01;
        end
        if (reset)
        begin
            r_d = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        r_q <= r_d;
    end

    assign lost = r_q.lost;

endmodule // clock_loss_detector

// File: hdl/reset_sources.sv
// Supply-monitor, reset-pin and clock-loss reset sequencer with its registers
`timescale 1ns/1ps
`include "reset_sources_cfg.svh"

module reset_sources
    import reset_sources_pkg::*;
#(
    parameter int PorDelayCycles =
        (`POR_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
)
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       supplyAbove,
    input  wire logic       resetPinIn,
    output logic            resetPinOut,
    output logic            resetPinOe,
    input  wire logic       clockSense,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    output logic [7:0]      rdData,
    output logic            coreReset,
    output logic            irq
);

    // Least times round up, so the monitor is never trusted too early
    localparam int SettleCycles =
        (`MONITOR_SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int ClockHoldCycles =
        (`CLOCK_HOLD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;

    seq_regs_t s_q;
    seq_regs_t s_d;

    logic       clockLost;
    logic       settled;
    logic       supplyOk;
    logic       supplyReq;
    logic       clockReq;
    logic       pinReq;
    logic [2:0] irqEvent;
    logic [2:0] irqClear;

    clock_loss_detector detector (
        .clock      (clock),
        .reset      (reset),
        .enable     (s_q.clockLossEn),
        .clockSense (clockSense),
        .lost       (clockLost)
    );

    always_comb
    begin
        s_d        = s_q;
        s_d.rdData = 8'h00;
        irqEvent   = 3'h0;
        irqClear   = 3'h0;

        // An unsettled monitor reports low supply, which is why selecting it early resets
        settled   = (s_q.settleCnt == 12'(SettleCycles));
        supplyOk  = supplyAbove && settled;
        supplyReq = s_q.monitorOn && s_q.supplySel && !supplyOk;
        clockReq  = s_q.clockLossEn && clockLost;
        // Our own drive of the pin must not look like an outside reset
        pinReq    = !resetPinIn && !s_q.pinOe;

        if (!s_q.monitorOn)
        begin
            s_d.settleCnt = 12'h000;
        end
        else if (!settled)
        begin
            s_d.settleCnt = s_q.settleCnt + 12'h001;
        end

        s_d.supplyPrev = supplyAbove;
        if (s_q.supplyPrev && !supplyAbove && s_q.monitorOn)
        begin
            irqEvent[`IRQ_SUPPLY_DROP] = 1'b1;
        end

        case (s_q.fsm)
            ST_POWER_ON:
            begin
                if (!supplyAbove)
                begin
                    s_d.holdCnt = 16'h0000;
                end
                else if (s_q.holdCnt >= 16'(PorDelayCycles - 1))
                begin
                    s_d.fsm        = ST_RUN;
                    s_d.coreReset  = 1'b0;
                    s_d.pinOe      = 1'b0;
                    s_d.causeFlags = `CAUSE_AFTER_POWER;
                    s_d.supplySel  = 1'b1;
                end
                else
                begin
                    s_d.holdCnt = s_q.holdCnt + 16'h0001;
                end
            end
            ST_RUN:
            begin
                s_d.holdCnt = 16'h0000;
                if (supplyReq)
                begin
                    s_d.fsm       = ST_HOLD;
                    s_d.pend      = CAUSE_SUPPLY;
                    s_d.coreReset = 1'b1;
                    s_d.pinOe     = 1'b1;
                end
                else if (clockReq)
                begin
                    s_d.fsm         = ST_CLOCKHOLD;
                    s_d.pend        = CAUSE_CLOCK;
                    s_d.coreReset   = 1'b1;
                    s_d.clockLossEn = 1'b0;
                    irqEvent[`IRQ_CLOCK_LOST] = 1'b1;
                end
                else if (pinReq)
                begin
                    s_d.fsm       = ST_HOLD;
                    s_d.pend      = CAUSE_PIN;
                    s_d.coreReset = 1'b1;
                    irqEvent[`IRQ_PIN_RESET] = 1'b1;
                end
            end
            ST_HOLD:
            begin
                if (s_q.pend == CAUSE_SUPPLY)
                begin
                    if (supplyOk || !s_q.monitorOn || !s_q.supplySel)
                    begin
                        // No power-on delay here: release on the very next edge
                        s_d.fsm         = ST_RUN;
                        s_d.pend        = CAUSE_NONE;
                        s_d.coreReset   = 1'b0;
                        s_d.pinOe       = 1'b0;
                        s_d.causeFlags  = `CAUSE_AFTER_POWER;
                        s_d.clockLossEn = 1'b0;
                    end
                end
                else if (supplyReq)
                begin
                    s_d.pend  = CAUSE_SUPPLY;
                    s_d.pinOe = 1'b1;
                end
                else if (resetPinIn)
                begin
                    s_d.fsm         = ST_RUN;
                    s_d.pend        = CAUSE_NONE;
                    s_d.coreReset   = 1'b0;
                    s_d.causeFlags  = `CAUSE_AFTER_PIN;
                    s_d.clockLossEn = 1'b0;
                end
            end
            ST_CLOCKHOLD:
            begin
                // The pin is left alone for this source
                s_d.pinOe = 1'b0;
                if (s_q.holdCnt == 16'(ClockHoldCycles - 1))
                begin
                    s_d.fsm        = ST_RUN;
                    s_d.pend       = CAUSE_NONE;
                    s_d.coreReset  = 1'b0;
                    s_d.holdCnt    = 16'h0000;
                    s_d.causeFlags = `CAUSE_AFTER_CLOCK;
                end
                else
                begin
                    s_d.holdCnt = s_q.holdCnt + 16'h0001;
                end
            end
            default:
            begin
                s_d.fsm = ST_POWER_ON;
            end
        endcase

        if (wrStrobe)
        begin
            case (addr)
                `ADDR_SUPPLY_CTRL:
                begin
                    // Only the on bit is stored, the rest is dropped
                    s_d.monitorOn = wrData[`BIT_MONITOR_ON];
                end
                `ADDR_RESET_CAUSE:
                begin
                    s_d.clockLossEn = wrData[`BIT_CLOCK_CAUSE];
                    s_d.supplySel   = wrData[`BIT_POWER_CAUSE];
                end
                `ADDR_IRQ_CLEAR:
                begin
                    irqClear = wrData[2:0];
                end
                `ADDR_IRQ_ENABLE:
                begin
                    s_d.irqEnable = wrData[2:0];
                end
                default:
                begin
                end
            endcase
        end

        // A new event in the clearing cycle stays set
        s_d.irqStatus = (s_q.irqStatus & ~irqClear) | irqEvent;
        s_d.irq       = |(s_d.irqStatus & s_d.irqEnable);

        if (rdStrobe)
        begin
            case (addr)
                `ADDR_SUPPLY_CTRL:
                begin
                    s_d.rdData = {s_q.monitorOn, supplyAbove, 6'h00};
                end
                `ADDR_RESET_CAUSE:
                begin
                    s_d.rdData = {5'h00, s_q.causeFlags};
                end
                `ADDR_IRQ_STATUS:
                begin
                    s_d.rdData = {5'h00, s_q.irqStatus};
                end
                `ADDR_IRQ_ENABLE:
                begin
                    s_d.rdData = {5'h00, s_q.irqEnable};
                end
                default:
                begin
                    s_d.rdData = 8'h00;
                end
            endcase
        end

        if (reset)
        begin
            s_d           = '0;
            s_d.fsm       = ST_POWER_ON;
            s_d.monitorOn = 1'b1;
            s_d.coreReset = 1'b1;
            s_d.pinOe     = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        s_q <= s_d;
    end

    // Open-drain pin only ever pulls low
    assign resetPinOut = 1'b0;
    assign resetPinOe  = s_q.pinOe;
    assign rdData      = s_q.rdData;
    assign coreReset   = s_q.coreReset;
    assign irq         = s_q.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // A one-cycle dip is rightly released at once, so two low samples are asked for
    a_supply_holds_core: assert property (
        (s_q.fsm == ST_RUN) && s_q.monitorOn && s_q.supplySel && !supplyAbove
        ##1 !supplyAbove |-> coreReset && resetPinOe [*2])
        else $error("supply below threshold did not hold core and pin");

    a_supply_fast_release: assert property (
        (s_q.fsm == ST_HOLD) && (s_q.pend == CAUSE_SUPPLY) && supplyAbove && settled
        |=> !coreReset && !resetPinOe && (s_q.causeFlags == 3'h2))
        else $error("supply recovery did not release at once");

    a_monitor_kept: assert property (
        !(wrStrobe && (addr == `ADDR_SUPPLY_CTRL))
        |=> s_q.monitorOn == $past(s_q.monitorOn))
        else $error("monitor state changed without a write");

    a_monitor_after_por: assert property (
        $fell(reset) |-> s_q.monitorOn && coreReset)
        else $error("power-on reset left monitor off");

    a_ctrl_readback: assert property (
        rdStrobe && (addr == 8'hFF)
        |=> (rdData[5:0] == 6'h00) && (rdData[6] == $past(supplyAbove))
            && (rdData[7] == $past(s_q.monitorOn)))
        else $error("control register read back wrong");

    a_ctrl_write: assert property (
        wrStrobe && (addr == 8'hFF) |=> s_q.monitorOn == $past(wrData[7]))
        else $error("monitor on bit not written");

    a_pin_enters: assert property (
        (s_q.fsm == ST_RUN) && !resetPinIn && !resetPinOe |=> coreReset)
        else $error("low reset pin did not reset");

    a_pin_flag: assert property (
        (s_q.fsm == ST_HOLD) && (s_q.pend == CAUSE_PIN) && resetPinIn && !supplyReq
        |=> !coreReset && (s_q.causeFlags == 3'h1))
        else $error("pin cause flag not set on exit");

    a_clock_resets: assert property (
        (s_q.fsm == ST_RUN) && !supplyReq && s_q.clockLossEn && clockLost
        |=> coreReset && !resetPinOe ##1 !s_q.clockLossEn)
        else $error("clock loss did not reset");

    a_clock_hold_len: assert property (
        $rose(s_q.fsm == ST_CLOCKHOLD) |-> coreReset [*4]
        ##1 !coreReset && (s_q.causeFlags == 3'h4))
        else $error("clock-loss hold length or flag wrong");

    a_clock_pin_free: assert property (
        (s_q.fsm == ST_CLOCKHOLD) |=> !resetPinOe)
        else $error("clock-loss reset drove the pin");

    c_supply_reset: cover property (
        (s_q.pend == CAUSE_SUPPLY) ##[1:50] !coreReset);
    c_pin_reset: cover property (
        (s_q.pend == CAUSE_PIN) ##[1:50] (s_q.causeFlags == 3'h1));
    c_clock_reset: cover property (
        (s_q.fsm == ST_CLOCKHOLD) ##[1:10] (s_q.causeFlags == 3'h4));
    c_irq_raised: cover property ($rose(irq));

endmodule // reset_sources

// File: tb/supply_pin_partner.sv
// Board-side model: supply comparator, pulled-up reset pin and monitored clock
`timescale 1ns/1ps

module supply_pin_partner
(
    input  wire logic clock,
    input  wire logic supplyOk,
    input  wire logic pullLow,
    input  wire logic stall,
    input  wire logic pinOe,
    input  wire logic pinOut,
    output logic      supplyAbove,
    output logic      resetPinIn,
    output logic      clockSense
);
    initial clockSense = 1'b0;

    assign supplyAbove = supplyOk;
    // Open-drain wire with pull-up; either party may pull it low
    assign resetPinIn = (pinOe ? pinOut : 1'b1) && !pullLow;

    // A stalled clock sticks at its last level, high or low
    always @(posedge clock)
    begin
        if (!stall)
            clockSense <= ~clockSense;
    end
endmodule // supply_pin_partner

// File: tb/reset_sources_tb.sv
// Self-checking bench for the reset-source block
`timescale 1ns/1ps
`include "reset_sources_cfg.svh"

module reset_sources_tb;
    import reset_sources_pkg::*;
    // Large enough that a delayed release is told apart from a prompt one
    localparam int PorCycles = 64;

    logic       clock    = 1'b0;
    logic       reset    = 1'b1;
    logic       supplyOk = 1'b1;
    logic       pullLow  = 1'b0;
    logic       stall    = 1'b0;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wrData   = 8'h00;
    logic       wrStrobe = 1'b0;
    logic       rdStrobe = 1'b0;
    logic       supplyAbove, resetPinIn, resetPinOut, resetPinOe, clockSense;
    logic       coreReset, irq;
    logic [7:0] rdData;
    int         mismatches = 0;
    int         checks     = 0;

    always #12.5 clock = ~clock;

    reset_sources #(.PorDelayCycles(PorCycles)) DUT (
        .clock(clock), .reset(reset), .supplyAbove(supplyAbove), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .clockSense(clockSense),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .coreReset(coreReset), .irq(irq));

    supply_pin_partner partner (
        .clock(clock), .supplyOk(supplyOk), .pullLow(pullLow), .stall(stall),
        .pinOe(resetPinOe), .pinOut(resetPinOut), .supplyAbove(supplyAbove),
        .resetPinIn(resetPinIn), .clockSense(clockSense));

    function automatic logic [7:0] ctrlExp(input logic on, input logic above);
        return {on, above, 6'h00};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask

    task automatic waitCore(input logic val, input int lim);
        int n;
        n = 0;
        // Never read an output in the time step of the edge that launches it
        #1;
        while (coreReset !== val && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk({7'h00, coreReset}, {7'h00, val});
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #(25 * 30000);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(50));
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        #1;
        chk({6'h00, coreReset, resetPinOe}, 8'h03);
        waitCore(1'b0, PorCycles + 20);
        cyc(4100);
        waitCore(1'b0, 4200);
        rd(`ADDR_RESET_CAUSE, `CAUSE_AFTER_POWER);
        rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b1, 1'b1));
        // Random low bits must never stick
        for (int i = 0; i < 6; i++)
        begin
            wr(`ADDR_SUPPLY_CTRL, 8'h80 | 8'($urandom() & 32'h7F));
            rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b1, 1'b1));
        end
        rd(8'h10, 8'h00);

        wr(`ADDR_IRQ_ENABLE, 8'h01);
        @(posedge clock) supplyOk <= 1'b0;
        waitCore(1'b1, 3);
        chk({7'h00, resetPinOe}, 8'h01);
        chk({7'h00, resetPinOut}, 8'h00);
        rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b1, 1'b0));
        chk({7'h00, irq}, 8'h01);
        @(posedge clock) supplyOk <= 1'b1;
        waitCore(1'b0, 3);
        rd(`ADDR_RESET_CAUSE, `CAUSE_AFTER_POWER);
        wr(`ADDR_IRQ_CLEAR, 8'h01);
        chk({7'h00, irq}, 8'h00);

        wr(`ADDR_SUPPLY_CTRL, 8'h00);
        rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b0, 1'b1));
        @(posedge clock) supplyOk <= 1'b0;
        cyc(10);
        chk({7'h00, coreReset}, 8'h00);
        @(posedge clock) supplyOk <= 1'b1;

        wr(`ADDR_IRQ_ENABLE, 8'h04);
        @(posedge clock) pullLow <= 1'b1;
        waitCore(1'b1, 3);
        chk({7'h00, resetPinOe}, 8'h00);
        cyc(5);
        @(posedge clock) pullLow <= 1'b0;
        waitCore(1'b0, 3);
        rd(`ADDR_RESET_CAUSE, `CAUSE_AFTER_PIN);
        rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b0, 1'b1));
        rd(`ADDR_IRQ_STATUS, 8'h04);
        chk({7'h00, irq}, 8'h01);
        wr(`ADDR_IRQ_ENABLE, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(`ADDR_IRQ_CLEAR, 8'h04);
        wr(`ADDR_IRQ_ENABLE, 8'h04);
        chk({7'h00, irq}, 8'h00);

        // Selecting before the monitor settles trips a supply reset
        wr(`ADDR_RESET_CAUSE, 8'h02);
        wr(`ADDR_SUPPLY_CTRL, 8'h80);
        waitCore(1'b1, 3);
        waitCore(1'b0, 4200);
        rd(`ADDR_RESET_CAUSE, `CAUSE_AFTER_POWER);
        rd(`ADDR_IRQ_ENABLE, 8'h04);
        // Proper order: switch on, let it settle, only then select
        wr(`ADDR_RESET_CAUSE, 8'h00);
        wr(`ADDR_SUPPLY_CTRL, 8'h00);
        wr(`ADDR_SUPPLY_CTRL, 8'h80);
        cyc(4010);
        wr(`ADDR_RESET_CAUSE, 8'h02);
        cyc(5);
        chk({7'h00, coreReset}, 8'h00);

        wr(`ADDR_RESET_CAUSE, 8'h06);
        @(posedge clock) stall <= 1'b1;
        waitCore(1'b1, 25);
        chk({7'h00, resetPinOe}, 8'h00);
        @(posedge clock) stall <= 1'b0;
        waitCore(1'b0, 6);
        rd(`ADDR_RESET_CAUSE, `CAUSE_AFTER_CLOCK);
        rd(`ADDR_IRQ_STATUS, 8'h02);

        wr(`ADDR_RESET_CAUSE, 8'h06);
        wr(`ADDR_RESET_CAUSE, 8'h02);
        @(posedge clock) stall <= 1'b1;
        cyc(40);
        chk({7'h00, coreReset}, 8'h00);
        @(posedge clock) stall <= 1'b0;

        // Power-on reset in mid-run turns the monitor back on
        wr(`ADDR_SUPPLY_CTRL, 8'h00);
        @(posedge clock) reset <= 1'b1;
        cyc(3);
        @(posedge clock) reset <= 1'b0;
        rd(`ADDR_SUPPLY_CTRL, ctrlExp(1'b1, 1'b1));
        chk({7'h00, coreReset}, 8'h01);
        wrap_up();
    end
endmodule // reset_sources_tb
